// File: bench/dtf_fe_model.sv
// Behavioural diode bias and ADC front end facing the formatter
`timescale 1ns/1ps
module dtf_fe_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Step request from the device
    input wire logic fe_start,
    input wire logic [1:0] fe_bias,
    input wire logic [1:0] fe_chan,
    // Step answer
    output logic fe_done_tgl,
    output logic [9:0] fe_data,
    output logic fe_fault,
    // Bench controls and step log
    input wire logic [9:0] temp,
    input wire logic flt,
    input wire logic [9:0] wob,
    input wire logic slow,
    output logic [7:0] seq_errs
);
    // One round as {chan, bias}: remote1 four steps, local one, remote2 four
    logic [3:0] order [9] = '{4'h0, 4'h1, 4'h0, 4'h2, 4'h4, 4'h8, 4'h9, 4'h8, 4'hA};
    int idx;
    int wait_n;
    logic flip;
    logic last_step;

    always @(posedge core_clk) begin
        if (!rst_b) begin
            idx <= 0;
            wait_n <= -1;
            flip <= 1'b0;
            last_step <= 1'b0;
            fe_done_tgl <= 1'b0;
            fe_data <= 10'h155;
            fe_fault <= 1'b0;
            seq_errs <= 8'h00;
        end else if (fe_start) begin
            // Saturate so a long run of slips cannot wrap back to zero
            if ({fe_chan, fe_bias} !== order[idx] && seq_errs != 8'hFF)
                seq_errs <= seq_errs + 8'h01;
            last_step <= (idx == 3) || (idx == 4) || (idx == 8);
            idx <= (idx == 8) ? 0 : idx + 1;
            wait_n <= slow ? 20 : 1;
            // Hold time over: never leave a stale sample that could pass by luck
            fe_data <= ~fe_data;
            fe_fault <= ~fe_fault;
        end else if (wait_n > 0) begin
            wait_n <= wait_n - 1;
        end else if (wait_n == 0) begin
            // Alternating wobble averages out only over an even window
            if (last_step) begin
                flip <= ~flip;
                fe_data <= flip ? temp + wob : temp - wob;
            end
            fe_fault <= flt;
            fe_done_tgl <= ~fe_done_tgl;
            wait_n <= -1;
        end
    end
endmodule

// File: bench/tb_diode_temp_result_formatter.sv
// Self-checking bench for the diode result formatter
`timescale 1ns/1ps
`include "dtf_defines.svh"
module tb_diode_temp_result_formatter;
    typedef struct {
        int t;
        int ofs;
        bit sc;
        bit fmt;
        bit flt;
        logic [7:0] val;
        logic [1:0] frac;
    } dtf_row_type;

    logic core_clk, rst_b, fmt_biased, reg_wr, reg_rd, fe_start, fe_done_tgl, fe_fault;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, seq_errs;
    logic [1:0] fe_bias, fe_chan;
    logic [9:0] fe_data, temp, wob;
    logic flt, slow;
    int n_errors = 0;
    int checks_done = 0;
    // Quarter degrees in, remote1 value byte and fraction bits out
    dtf_row_type rows [11] = '{
        '{0, 0, 0, 0, 0, 8'h00, 2'h0}, '{41, 0, 0, 0, 0, 8'h0A, 2'h1},
        '{102, 4, 0, 0, 0, 8'h1B, 2'h2}, '{203, -3, 1, 0, 0, 8'h2F, 2'h3},
        '{-200, 0, 0, 1, 0, 8'h0E, 2'h0}, '{500, 10, 1, 0, 0, 8'h7F, 2'h3},
        '{-500, -10, 0, 1, 0, 8'h01, 2'h0}, '{0, 0, 0, 0, 1, 8'h80, 2'h0},
        '{0, 0, 0, 1, 1, 8'h00, 2'h0}, '{-252, 0, 0, 0, 0, 8'hC1, 2'h0},
        '{500, 66, 1, 1, 0, 8'hFF, 2'h0}};

    dtf_top i_dtf_top (.core_clk, .rst_b, .fmt_biased, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .fe_start, .fe_bias, .fe_chan, .fe_done_tgl, .fe_data,
        .fe_fault);
    dtf_fe_model i_dtf_fe_model (.core_clk, .rst_b, .fe_start, .fe_bias, .fe_chan,
        .fe_done_tgl, .fe_data, .fe_fault, .temp, .flt, .wob, .slow, .seq_errs);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] w);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = w;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] r);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        r = reg_rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] r;
        reg_read(a, r);
        check(r, exp);
    endtask

    // Offset added, store saturated, then encoded with the fault code reserved
    function automatic logic [9:0] code_of(input int t, input int oq, input bit fmt,
                                           input bit fl);
        int v;
        v = t + oq;
        if (v < -508) v = -508;
        if (v > 767) v = 767;
        if (!fmt) begin
            if (v > 511) v = 511;
            return fl ? 10'h200 : v[9:0];
        end
        v = v + 256;
        if (v < 4) v = 4;
        if (v > 1023) v = 1023;
        return fl ? 10'h000 : v[9:0];
    endfunction

    // Remote1 gets +ofs, local none, remote2 -ofs
    task automatic run_row(input dtf_row_type r, input int settle);
        logic [9:0] cl, c2;
        int m, n;
        m = r.sc ? 4 : 2;
        n = -r.ofs;
        temp = r.t[9:0];
        flt = r.flt;
        fmt_biased = r.fmt;
        reg_write(`DTF_REG_OFS_REMOTE1, r.ofs[7:0]);
        reg_write(`DTF_REG_OFS_LOCAL, 8'h00);
        reg_write(`DTF_REG_OFS_REMOTE2, n[7:0]);
        reg_write(`DTF_REG_CONFIG, {6'h00, r.sc, 1'b0});
        repeat (settle) @(negedge core_clk);
        cl = code_of(r.t, 0, r.fmt, r.flt);
        c2 = code_of(r.t, n * m, r.fmt, r.flt);
        rd_chk(`DTF_REG_FRACTION, {cl[1:0], c2[1:0], r.frac, 2'b00});
        rd_chk(`DTF_REG_REMOTE1, r.val);
        rd_chk(`DTF_REG_LOCAL, cl[9:2]);
        rd_chk(`DTF_REG_REMOTE2, c2[9:2]);
    endtask

    initial begin
        // Sixteen rounds at the slow answer rate, twice over, plus all rows
        repeat (80000) @(posedge core_clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        rst_b = 1'b0;
        fmt_biased = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        temp = 10'h000;
        flt = 1'b0;
        wob = 10'h000;
        slow = 1'b0;
        repeat (4) @(negedge core_clk);
        check({7'h00, fe_start}, 8'h00);
        check({4'h0, fe_bias, fe_chan}, 8'h00);
        rst_b = 1'b1;
        rd_chk(`DTF_REG_OFS_REMOTE1, 8'h00);
        rd_chk(`DTF_REG_OFS_LOCAL, 8'h00);
        rd_chk(`DTF_REG_OFS_REMOTE2, 8'h00);
        rd_chk(`DTF_REG_CONFIG, 8'h00);
        rd_chk(`DTF_REG_REMOTE1, 8'h00);
        fmt_biased = 1'b1;
        rd_chk(`DTF_REG_LOCAL, 8'h40);
        reg_write(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00);
        reg_write(`DTF_REG_CONFIG, 8'hFF);
        rd_chk(`DTF_REG_CONFIG, 8'hFF);
        $display("Reset and register map test done");
        foreach (rows[i]) run_row(rows[i], 2600);
        $display("Encoding and offset rows done");
        // Slow answers with alternating samples: only a true mean gives 25 C
        wob = 10'h008;
        slow = 1'b1;
        run_row('{100, 0, 0, 0, 0, 8'h19, 2'h0}, 9000);
        wob = 10'h000;
        slow = 1'b0;
        $display("Averaging test done");
        run_row('{40, 0, 0, 0, 0, 8'h0A, 2'h0}, 2600);
        rd_chk(`DTF_REG_FRACTION, 8'h00);
        temp = 10'h078;
        repeat (2600) @(negedge core_clk);
        rd_chk(`DTF_REG_REMOTE1, 8'h0A);
        rd_chk(`DTF_REG_LOCAL, 8'h0A);
        rd_chk(`DTF_REG_REMOTE2, 8'h0A);
        repeat (2) @(negedge core_clk);
        rd_chk(`DTF_REG_REMOTE1, 8'h1E);
        fmt_biased = 1'b1;
        rd_chk(`DTF_REG_LOCAL, 8'h5E);
        check(seq_errs, 8'h00);
        $display("Freeze and format switch test done");
        wrap_up();
    end
endmodule

// File: rtl/dtf_avg.sv
// Per-channel sixteen-sample averager
`timescale 1ns/1ps
`include "dtf_defines.svh"
module dtf_avg (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Samples in, means out
    dtf_avg_if.avg bus
);
    logic [2:0] wrap_w;
    logic [9:0] mean_w [0:2];
    logic rv_q;
    logic [1:0] rch_q;
    logic [9:0] res_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ch
            logic signed [13:0] acc_q;
            logic [3:0] cnt_q;
            logic hit_w;
            logic [13:0] sum_w;
            assign hit_w = bus.sample_valid && bus.sample_chan == 2'(g);
            assign sum_w = acc_q + {{4{bus.sample[9]}}, bus.sample};
            assign wrap_w[g] = hit_w && cnt_q == `DTF_AVG_LAST;
            // Floor rounding: arithmetic shift of the 16-sample sum
            assign mean_w[g] = sum_w[13:`DTF_AVG_SHIFT];
            always_ff @(posedge core_clk) begin
                if (!rst_b) begin
                    acc_q <= 14'sh0000;
                    cnt_q <= 4'h0;
                end else if (hit_w) begin
                    cnt_q <= cnt_q + 4'h1;
                    acc_q <= wrap_w[g] ? 14'sh0000 : sum_w;
                end
            end
            a_avg_window: assert property (wrap_w[g] |=> bus.result_valid &&
                bus.result_chan == 2'(g) && cnt_q == 4'h0)
                else $error("average not emitted after sixteenth sample");
            a_avg_count: assert property (hit_w && cnt_q != `DTF_AVG_LAST |=>
                !(bus.result_valid && bus.result_chan == 2'(g)))
                else $error("average emitted before sixteen samples");
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rv_q <= 1'b0;
            rch_q <= 2'h0;
            res_q <= 10'h000;
        end else begin
            rv_q <= |wrap_w;
            if (|wrap_w) begin
                rch_q <= bus.sample_chan;
                res_q <= mean_w[bus.sample_chan];
            end
        end
    end

    assign bus.result_valid = rv_q;
    assign bus.result_chan = rch_q;
    assign bus.result = res_q;

    c_avg_out: cover property (bus.result_valid && bus.result_chan == 2'h1);
endmodule

// File: rtl/dtf_avg_if.sv
// Sample and averaged-result carrier between sequencer and averager
`timescale 1ns/1ps
interface dtf_avg_if;
    logic sample_valid;
    logic [1:0] sample_chan;
    logic [9:0] sample;
    logic result_valid;
    logic [1:0] result_chan;
    logic [9:0] result;
    modport feed (output sample_valid, sample_chan, sample,
                  input result_valid, result_chan, result);
    modport avg (input sample_valid, sample_chan, sample,
                 output result_valid, result_chan, result);
endinterface

// File: rtl/dtf_defines.svh
// Offsets, field positions, reset values and counts for the diode result formatter
// Function
// - Signed format is twos-complement whole degrees -128..127; -128 marks diode fault.
// - Biased format adds 64 so 0 degrees is 0x40; all-zero marks fault.
// - Results are 10 bits; two quarter-degree bits go to the shared fraction register.
// - Each reported value is the mean of sixteen consecutive measurement cycles.
// - Remote results are kept at full 10-bit width in twos complement.
// - Remote conversion steps bias base/first multiple, then base/second multiple.
// - The channel's signed calibration offset is added to every averaged result before storing.
// - Local temperature whole-degree bits sit in their own value register.
// - Reading fraction first freezes all value registers until each one is read.
// - Each diode offset is an 8-bit twos-complement value added per channel.
// - Configuration bit scales offset LSB to half a degree or one degree.
`ifndef DTF_DEFINES_SVH
`define DTF_DEFINES_SVH

`define DTF_REG_REMOTE1 8'h25
`define DTF_REG_LOCAL 8'h26
`define DTF_REG_REMOTE2 8'h27
`define DTF_REG_FRACTION 8'h77
`define DTF_REG_OFS_REMOTE1 8'h70
`define DTF_REG_OFS_LOCAL 8'h71
`define DTF_REG_OFS_REMOTE2 8'h72
`define DTF_REG_CONFIG 8'h7C
`define DTF_CFG_SCALE_BIT 1
`define DTF_RESET_BYTE 8'h00
`define DTF_UNMAPPED_BYTE 8'h00

`define DTF_AVG_LAST 4'hF
`define DTF_AVG_SHIFT 4
`define DTF_REMOTE_LAST_STEP 2'h3

// Internal value is signed quarter degrees
`define DTF_STORE_MIN 12'shE04
`define DTF_STORE_MAX 12'sh2FF
`define DTF_TWOS_MAX 12'sh1FF
`define DTF_TWOS_FAULT 10'h200
`define DTF_BIAS_ADD 13'sh0100
`define DTF_BIASED_MIN 13'sh0004
`define DTF_BIASED_MAX 13'sh03FF
`define DTF_BIASED_FAULT 10'h000

`endif

// File: rtl/dtf_pkg.sv
// Types shared by the diode result formatter
package dtf_pkg;
    typedef enum logic [1:0] {DTF_BIAS_BASE, DTF_BIAS_FIRST, DTF_BIAS_SECOND} dtf_bias_type;
    typedef enum logic [1:0] {DTF_CH_REMOTE1, DTF_CH_LOCAL, DTF_CH_REMOTE2} dtf_chan_type;
    typedef enum logic [1:0] {DTF_ST_START, DTF_ST_WAIT} dtf_state_type;
endpackage

// File: rtl/dtf_top.sv
// Diode bias sequencer, offset, encoding and value/fraction registers
`timescale 1ns/1ps
`include "dtf_defines.svh"
module dtf_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Encoding select
    input wire logic fmt_biased,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Analog bias and ADC front end
    output logic fe_start,
    output logic [1:0] fe_bias,
    output logic [1:0] fe_chan,
    input wire logic fe_done_tgl,
    input wire logic [9:0] fe_data,
    input wire logic fe_fault
);
    dtf_pkg::dtf_state_type st_q;
    dtf_pkg::dtf_chan_type chan_q;
    dtf_pkg::dtf_chan_type next_chan_w;
    dtf_pkg::dtf_bias_type fe_bias_q;
    logic [1:0] step_q;
    logic fe_start_q;
    logic done_s1_q, done_s2_q, done_s3_q;
    logic done_evt_w;
    logic last_w;
    logic push_q;
    logic [9:0] push_data_q;
    logic push_fault_q;
    logic [7:0] ofs_q [0:2];
    logic [7:0] cfg_q;
    logic [2:0] fault_seen_q;
    logic signed [11:0] live_temp_q [0:2];
    logic [2:0] live_fault_q;
    logic signed [11:0] shown_temp_q [0:2];
    logic [2:0] shown_fault_q;
    logic freeze_q;
    logic [2:0] seen_q;
    logic [2:0] seen_d;
    logic [7:0] rdata_q;
    logic [9:0] code_w [0:2];
    logic [7:0] frac_w;
    logic [7:0] rd_mux_w;
    logic rd_frac_w;
    logic [2:0] rd_val_w;
    logic [2:0] wr_ofs_w;
    logic wr_cfg_w;
    logic [1:0] rch_w;
    logic [7:0] rofs_w;
    logic signed [11:0] res_ext_w;
    logic signed [11:0] ofs_scl_w;
    logic signed [11:0] sum_w;
    logic signed [11:0] store_w;
    logic signed [11:0] chk_expect_w;

    dtf_avg_if avg_bus();

    dtf_avg u_avg (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .bus(avg_bus)
    );

    function automatic dtf_pkg::dtf_bias_type bias_of(input dtf_pkg::dtf_chan_type ch,
                                                     input logic [1:0] st);
        if (ch == dtf_pkg::DTF_CH_LOCAL || !st[0])
            return dtf_pkg::DTF_BIAS_BASE;
        return st[1] ? dtf_pkg::DTF_BIAS_SECOND : dtf_pkg::DTF_BIAS_FIRST;
    endfunction

    // Encoding is applied on the read side, so a format change shows at once everywhere
    function automatic logic [9:0] enc(input logic signed [11:0] t, input logic flt,
                                       input logic bsd);
        logic signed [12:0] b;
        b = {t[11], t} + `DTF_BIAS_ADD;
        if (flt)
            return bsd ? `DTF_BIASED_FAULT : `DTF_TWOS_FAULT;
        if (bsd) begin
            if (b < `DTF_BIASED_MIN)
                return 10'(`DTF_BIASED_MIN);
            if (b > `DTF_BIASED_MAX)
                return 10'(`DTF_BIASED_MAX);
            return b[9:0];
        end
        if (t > `DTF_TWOS_MAX)
            return 10'(`DTF_TWOS_MAX);
        return t[9:0];
    endfunction

    // Front-end completion arrives as a toggle from the analog side
    assign done_evt_w = done_s2_q ^ done_s3_q;
    assign last_w = (chan_q == dtf_pkg::DTF_CH_LOCAL) ? (step_q == 2'h0)
                                                      : (step_q == `DTF_REMOTE_LAST_STEP);
    assign next_chan_w = (chan_q == dtf_pkg::DTF_CH_REMOTE1) ? dtf_pkg::DTF_CH_LOCAL :
                         (chan_q == dtf_pkg::DTF_CH_LOCAL) ? dtf_pkg::DTF_CH_REMOTE2 :
                         dtf_pkg::DTF_CH_REMOTE1;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
        end else begin
            done_s1_q <= fe_done_tgl;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_q <= dtf_pkg::DTF_ST_START;
            chan_q <= dtf_pkg::DTF_CH_REMOTE1;
            step_q <= 2'h0;
            fe_start_q <= 1'b0;
            fe_bias_q <= dtf_pkg::DTF_BIAS_BASE;
            push_q <= 1'b0;
            push_data_q <= 10'h000;
            push_fault_q <= 1'b0;
        end else begin
            fe_start_q <= 1'b0;
            push_q <= 1'b0;
            case (st_q)
                dtf_pkg::DTF_ST_START: begin
                    fe_start_q <= 1'b1;
                    fe_bias_q <= bias_of(chan_q, step_q);
                    st_q <= dtf_pkg::DTF_ST_WAIT;
                end
                dtf_pkg::DTF_ST_WAIT: begin
                    if (done_evt_w) begin
                        st_q <= dtf_pkg::DTF_ST_START;
                        if (last_w) begin
                            push_q <= 1'b1;
                            push_data_q <= fe_data;
                            push_fault_q <= fe_fault;
                            step_q <= 2'h0;
                            chan_q <= next_chan_w;
                        end else begin
                            step_q <= step_q + 2'h1;
                        end
                    end
                end
                default: st_q <= dtf_pkg::DTF_ST_START;
            endcase
        end
    end

    assign avg_bus.sample_valid = push_q;
    assign avg_bus.sample_chan = chan_q == dtf_pkg::DTF_CH_REMOTE1 ? 2'h2 : chan_q - 2'h1;
    assign avg_bus.sample = push_data_q;

    // Offset path on each averaged result
    assign rch_w = avg_bus.result_chan;
    assign rofs_w = ofs_q[rch_w];
    assign res_ext_w = {{2{avg_bus.result[9]}}, avg_bus.result};
    assign ofs_scl_w = cfg_q[`DTF_CFG_SCALE_BIT] ? {{2{rofs_w[7]}}, rofs_w, 2'b00}
                                                 : {{3{rofs_w[7]}}, rofs_w, 1'b0};
    assign sum_w = res_ext_w + ofs_scl_w;
    // Saturate so a large offset can never forge the fault code
    assign store_w = (sum_w < `DTF_STORE_MIN) ? `DTF_STORE_MIN :
                     (sum_w > `DTF_STORE_MAX) ? `DTF_STORE_MAX : sum_w;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            fault_seen_q <= 3'h0;
            live_fault_q <= 3'h0;
            for (int i = 0; i < 3; i++)
                live_temp_q[i] <= 12'sh000;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (avg_bus.result_valid && rch_w == 2'(i)) begin
                    live_temp_q[i] <= store_w;
                    live_fault_q[i] <= fault_seen_q[i];
                    fault_seen_q[i] <= 1'b0;
                end
                // Set wins over the window clear
                if (push_q && push_fault_q && avg_bus.sample_chan == 2'(i))
                    fault_seen_q[i] <= 1'b1;
            end
        end
    end

    // Register decode
    assign rd_frac_w = reg_rd && reg_addr == `DTF_REG_FRACTION;
    assign rd_val_w = {reg_rd && reg_addr == `DTF_REG_REMOTE2,
                       reg_rd && reg_addr == `DTF_REG_LOCAL,
                       reg_rd && reg_addr == `DTF_REG_REMOTE1};
    assign wr_ofs_w = {reg_wr && reg_addr == `DTF_REG_OFS_REMOTE2,
                       reg_wr && reg_addr == `DTF_REG_OFS_LOCAL,
                       reg_wr && reg_addr == `DTF_REG_OFS_REMOTE1};
    assign wr_cfg_w = reg_wr && reg_addr == `DTF_REG_CONFIG;
    assign seen_d = seen_q | rd_val_w;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_code
            assign code_w[g] = enc(shown_temp_q[g], shown_fault_q[g], fmt_biased);
        end
    endgenerate

    assign frac_w = {code_w[1][1:0], code_w[2][1:0], code_w[0][1:0], 2'b00};
    assign rd_mux_w = rd_val_w[0] ? code_w[0][9:2] :
                      rd_val_w[1] ? code_w[1][9:2] :
                      rd_val_w[2] ? code_w[2][9:2] :
                      rd_frac_w ? frac_w :
                      (reg_addr == `DTF_REG_OFS_REMOTE1) ? ofs_q[0] :
                      (reg_addr == `DTF_REG_OFS_LOCAL) ? ofs_q[1] :
                      (reg_addr == `DTF_REG_OFS_REMOTE2) ? ofs_q[2] :
                      (reg_addr == `DTF_REG_CONFIG) ? cfg_q : `DTF_UNMAPPED_BYTE;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cfg_q <= `DTF_RESET_BYTE;
            rdata_q <= 8'h00;
            for (int i = 0; i < 3; i++)
                ofs_q[i] <= `DTF_RESET_BYTE;
        end else begin
            if (reg_rd)
                rdata_q <= rd_mux_w;
            if (wr_cfg_w)
                cfg_q <= reg_wdata;
            for (int i = 0; i < 3; i++)
                if (wr_ofs_w[i])
                    ofs_q[i] <= reg_wdata;
        end
    end

    // Snapshot shown to host; held from the fraction read until all values are read
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            freeze_q <= 1'b0;
            seen_q <= 3'h0;
            shown_fault_q <= 3'h0;
            for (int i = 0; i < 3; i++)
                shown_temp_q[i] <= 12'sh000;
        end else begin
            if (rd_frac_w) begin
                freeze_q <= 1'b1;
                seen_q <= 3'h0;
            end else if (freeze_q) begin
                seen_q <= seen_d;
                if (&seen_d)
                    freeze_q <= 1'b0;
            end
            if (!freeze_q && !rd_frac_w) begin
                shown_fault_q <= live_fault_q;
                for (int i = 0; i < 3; i++)
                    shown_temp_q[i] <= live_temp_q[i];
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign fe_start = fe_start_q;
    assign fe_bias = fe_bias_q;
    assign fe_chan = chan_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    assign chk_expect_w = {2'b00, avg_bus.result} + ({{4{ofs_q[0][7]}}, ofs_q[0]} <<< 1);

    a_fault_twos: assert property (shown_fault_q[0] && !fmt_biased |->
        code_w[0] == 10'h200) else $error("twos fault code wrong");
    a_twos_no_forge: assert property (!shown_fault_q[1] && !fmt_biased |->
        code_w[1] != 10'h200) else $error("good value shows fault code");
    a_fault_biased: assert property (shown_fault_q[2] && fmt_biased |->
        code_w[2] == 10'h000) else $error("biased fault code wrong");
    a_biased_zero: assert property (!shown_fault_q[1] && fmt_biased &&
        shown_temp_q[1] == 12'sh000 |-> code_w[1] == 10'h100) else $error("0C not 0x40");
    a_frac_read: assert property (rd_frac_w |=> reg_rdata == {$past(code_w[1][1:0]),
        $past(code_w[2][1:0]), $past(code_w[0][1:0]), 2'b00}) else $error("fraction wrong");
    a_local_read: assert property (rd_val_w[1] |=> reg_rdata == $past(code_w[1][9:2]))
        else $error("local value wrong");
    a_bias_first: assert property (st_q == dtf_pkg::DTF_ST_WAIT && done_evt_w &&
        chan_q != dtf_pkg::DTF_CH_LOCAL && step_q == 2'h0 |-> ##2 fe_start &&
        fe_bias == dtf_pkg::DTF_BIAS_FIRST) else $error("first multiple step missing");
    a_bias_second: assert property (st_q == dtf_pkg::DTF_ST_WAIT && done_evt_w &&
        chan_q != dtf_pkg::DTF_CH_LOCAL && step_q == 2'h2 |-> ##2 fe_start &&
        fe_bias == dtf_pkg::DTF_BIAS_SECOND) else $error("second multiple step missing");
    a_offset_half: assert property (avg_bus.result_valid && rch_w == 2'h0 &&
        !cfg_q[1] && avg_bus.result[9:8] == 2'b00 |=> live_temp_q[0] == $past(chk_expect_w))
        else $error("offset not added at half degree");
    a_freeze_hold: assert property (freeze_q |=> $stable(shown_temp_q[0]) &&
        $stable(shown_temp_q[1]) && $stable(shown_temp_q[2])) else $error("frozen value moved");
    a_unfreeze: assert property (freeze_q && !rd_frac_w && &seen_d |=> !freeze_q)
        else $error("freeze not released");

    c_freeze_cycle: cover property (rd_frac_w ##[1:20] !freeze_q);
    c_fault_read: cover property (shown_fault_q[0] && rd_val_w[0]);
    c_biased_read: cover property (fmt_biased && rd_val_w[2]);
endmodule
